// ### irg_carrier.sv
// Carrier clock enable divider and carrier waveform generator
`timescale 1ns/1ps
module irg_carrier (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Configuration
   input wire logic clock_gate_i,
   input wire logic [irg_pkg::IRG_DIV_W-1:0] carrier_div_i,
   input wire logic [irg_pkg::IRG_CNT_W-1:0] carrier_high_i,
   input wire logic [irg_pkg::IRG_CNT_W-1:0] carrier_low_i,
   // Control and result
   input wire logic run_i,
   output logic tick_o,
   output logic carrier_o
);
   import irg_pkg::*;

   typedef struct packed {
      logic [IRG_DIV_W-1:0] div;
      logic [IRG_CNT_W-1:0] cnt;
      logic tick;
      logic level;
   } irg_car_t;

   irg_car_t q;
   irg_car_t d;
   logic [IRG_CNT_W-1:0] limit;

   assign tick_o = q.tick;
   assign carrier_o = q.level;
   assign limit = q.level ? carrier_high_i : carrier_low_i;

   // Divider and high/low phase counter
   always_comb
   begin
      d = q;
      d.tick = 1'b0;
      if (clock_gate_i)
      begin
         if (q.div >= carrier_div_i)
         begin
            d.div = IRG_DIV_RST;
            d.tick = 1'b1;
         end
         else
         begin
            d.div = q.div + 1'b1;
         end
      end
      else
      begin
         d.div = IRG_DIV_RST;
      end
      if (!run_i)
      begin
         d.cnt = IRG_CNT_RST;
         d.level = 1'b1; // Each mark opens high
      end
      else if (d.tick)
      begin
         if (q.level && carrier_low_i == IRG_CNT_RST)
         begin
            d.cnt = IRG_CNT_RST; // No low phase: plain time mode
         end
         else if (q.cnt + IRG_CNT_ONE >= limit)
         begin
            d.cnt = IRG_CNT_RST; // RULE8
            d.level = !q.level; // RULE8
         end
         else
         begin
            d.cnt = q.cnt + IRG_CNT_ONE;
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.level <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

endmodule : irg_carrier

// ### irg_emitter.sv
// Behavioural infrared emitter that logs lit pulse widths
`timescale 1ns/1ps
module irg_emitter (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Modulated line
   input wire logic ir_i
);
   int widths[$];
   int lit;
   // Measure each lit stretch in clock cycles, log it when dark
   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         lit = 0;
      end
      else if (ir_i === 1'b1)
      begin
         lit++;
      end
      else if (lit > 0)
      begin
         widths.push_back(lit);
         lit = 0;
      end
   end
endmodule : irg_emitter

// ### irg_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module irg_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   import irg_pkg::*;

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic ready;
      logic valid;
   } irg_fifo_t;

   irg_fifo_t q;
   irg_fifo_t d;
   logic push;
   logic pop;

   // ==========================================================
   // Handshake
   assign in_ready_o = q.ready;
   assign out_valid_o = q.valid;
   assign out_data_o = q.mem[q.rd];
   assign push = in_valid_i && q.ready;
   assign pop = out_ready_i && q.valid;

   // Next state: pointers, count and registered flags
   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wr] = in_data_i;
         d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
      end
      if (pop)
      begin
         d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
      end
      if (push && !pop)
      begin
         d.cnt = q.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         d.cnt = q.cnt - 1'b1;
      end
      // Flags kept in flops so both handshake outputs are registered
      d.ready = (d.cnt != (AW + 1)'(DEPTH));
      d.valid = (d.cnt != '0);
   end

   // State register
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.ready <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

endmodule : irg_fifo

// ### irg_pkg.sv
// Shared constants and types for the infrared code transmitter
package irg_pkg;

   // ==========================================================
   // Data word layout
   localparam int IRG_WORD_W = 16;
   localparam int IRG_KIND_BIT = 15;
   localparam int IRG_LEN_MSB = 14;
   localparam int IRG_LEN_LSB = 11;
   localparam int IRG_PAY_MSB = 10;
   localparam int IRG_SYM_LVL_BIT = 14;
   localparam int IRG_DUR_MSB = 13;
   localparam logic [3:0] IRG_MAX_BIT_IDX = 4'hA;

   // ==========================================================
   // Queue sizes
   localparam int IRG_CODE_DEPTH = 32;
   localparam int IRG_RPT_DEPTH = 8;
   localparam logic [3:0] IRG_RPT_FULL = 4'h8;

   // ==========================================================
   // Counter widths and reset values
   localparam int IRG_CNT_W = 16;
   localparam int IRG_DIV_W = 8;
   localparam int IRG_TMR_W = 24;
   localparam logic [15:0] IRG_CNT_RST = 16'h0000;
   localparam logic [15:0] IRG_CNT_ONE = 16'h0001;
   localparam logic [23:0] IRG_TMR_RST = 24'h000000;
   localparam logic [7:0] IRG_DIV_RST = 8'h00;

   // ==========================================================
   // Timing
   localparam int IRG_CLK_PERIOD_PS = 5000;
   localparam int IRG_CARRIER_MAX_KHZ = 16000;

   // Sequencer states
   typedef enum logic [2:0] {
      IRG_ST_IDLE = 3'b000,
      IRG_ST_FETCH = 3'b001,
      IRG_ST_LOAD = 3'b010,
      IRG_ST_SYM = 3'b011,
      IRG_ST_GAP = 3'b100
   } irg_state_t;

endpackage : irg_pkg

// ### irg_top.sv
// Infrared code transmitter: queues, decoder, modulator, output stage
//
// Overview of operation
// RULE1 - Word bit 15 set means logic-bit message, clear means painted symbol
// RULE2 - Logic-bit message: bits 14:11 count minus one, payload in 10:0
// RULE3 - Painted symbol: bit 14 mark or space, bits 13:0 length
// RULE4 - Words queue up, then decode into mark and space commands
// RULE5 - A second queue holds the words sent when a key repeats
// RULE6 - While key held, resend repeat words each interval automatically
// RULE7 - Carrier runs on its own gated clock rate, up to 16 MHz
// RULE8 - Carrier stays high for one count, low for another
// RULE9 - Modulator gate passes or blocks carrier per command kind
// RULE10 - Output stage inverts final signal when inversion is selected
// RULE11 - Each bit is a mark plus a space of programmed lengths
// RULE12 - Per-bit order select: mark first or space first
// RULE13 - Software fills the queue then fires the transmit trigger
// RULE14 - Software enables the clock gate before using the block
// RULE15 - Code queue holds 32 words of 16 bits
// RULE16 - Completion of the queued command raises a done event
// RULE17 - Configuration is reached apart from the carrier timing domain
// RULE18 - Payload sent most significant valid bit first, words in order
// RULE19 - Output returns to idle space level, after inversion, when done
`timescale 1ns/1ps
module irg_top (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Carrier configuration
   input wire logic infrared_clock_gate_i,
   input wire logic [irg_pkg::IRG_DIV_W-1:0] carrier_div_i,
   input wire logic [irg_pkg::IRG_CNT_W-1:0] carrier_high_i,
   input wire logic [irg_pkg::IRG_CNT_W-1:0] carrier_low_i,
   // Bit timing and format
   input wire logic [irg_pkg::IRG_CNT_W-1:0] one_mark_i,
   input wire logic [irg_pkg::IRG_CNT_W-1:0] one_space_i,
   input wire logic [irg_pkg::IRG_CNT_W-1:0] zero_mark_i,
   input wire logic [irg_pkg::IRG_CNT_W-1:0] zero_space_i,
   input wire logic one_bit_order_select_i,
   input wire logic zero_bit_order_select_i,
   input wire logic invert_i,
   // Generator control
   input wire logic transmit_trigger_i,
   input wire logic key_held_i,
   input wire logic [irg_pkg::IRG_TMR_W-1:0] repeat_interval_i,
   // Code queue write side
   input wire logic code_valid_i,
   input wire logic [irg_pkg::IRG_WORD_W-1:0] code_data_i,
   output logic code_ready_o,
   // Repeat queue write side
   input wire logic rpt_wr_i,
   input wire logic rpt_clear_i,
   input wire logic [irg_pkg::IRG_WORD_W-1:0] rpt_data_i,
   output logic [3:0] rpt_count_o,
   // Status and line
   output logic busy_o,
   output logic tx_done_o,
   output logic ir_out_o
);
   import irg_pkg::*;

   typedef struct packed {
      irg_state_t st;
      logic src_rpt;
      logic [IRG_WORD_W-1:0] word;
      logic [3:0] bit_idx;
      logic half;
      logic [IRG_CNT_W-1:0] cnt;
      logic gate;
      logic [IRG_RPT_DEPTH-1:0][IRG_WORD_W-1:0] rpt_mem;
      logic [3:0] rpt_cnt;
      logic [2:0] rpt_idx;
      logic [IRG_TMR_W-1:0] tmr;
      logic busy;
      logic done;
      logic out;
   } irg_main_t;

   irg_main_t q;
   irg_main_t d;
   logic code_valid;
   logic [IRG_WORD_W-1:0] code_word;
   logic code_pop;
   logic tick;
   logic carrier;
   logic sym_done;
   logic bit_val;
   logic mark_first;
   logic level;
   logic [IRG_CNT_W-1:0] dur;

   // ==========================================================
   // Message field decoding
   function automatic logic irg_is_logic(input logic [IRG_WORD_W-1:0] w);
      irg_is_logic = w[IRG_KIND_BIT]; // RULE1
   endfunction : irg_is_logic

   function automatic logic [3:0] irg_top_bit(
      input logic [IRG_WORD_W-1:0] w);
      logic [3:0] n;
      n = w[IRG_LEN_MSB:IRG_LEN_LSB]; // RULE2
      irg_top_bit = (n > IRG_MAX_BIT_IDX) ? IRG_MAX_BIT_IDX : n;
   endfunction : irg_top_bit

   // ==========================================================
   // Code queue, 32 words deep
   irg_fifo #(
      .WIDTH(IRG_WORD_W),
      .DEPTH(IRG_CODE_DEPTH) // RULE15
   ) u_code_q (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(code_valid_i),
      .in_data_i(code_data_i), // RULE17
      .in_ready_o(code_ready_o),
      .out_valid_o(code_valid),
      .out_data_o(code_word),
      .out_ready_i(code_pop)
   );

   // ==========================================================
   // Carrier generator, gated by the modulator
   irg_carrier u_carrier (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .clock_gate_i(infrared_clock_gate_i), // RULE14
      .carrier_div_i(carrier_div_i), // RULE7
      .carrier_high_i(carrier_high_i),
      .carrier_low_i(carrier_low_i),
      .run_i(q.gate), // RULE9
      .tick_o(tick),
      .carrier_o(carrier)
   );

   // Queue pops only while the code source is being fetched
   assign code_pop = (q.st == IRG_ST_FETCH) && !q.src_rpt && tick; // RULE18

   // ==========================================================
   // Outputs straight from the state register
   assign busy_o = q.busy;
   assign tx_done_o = q.done;
   assign ir_out_o = q.out;
   assign rpt_count_o = q.rpt_cnt;

   // ==========================================================
   // Symbol selection for the word being emitted
   always_comb
   begin
      bit_val = q.word[q.bit_idx];
      mark_first = bit_val ? !one_bit_order_select_i
                           : !zero_bit_order_select_i; // RULE12
      if (irg_is_logic(q.word))
      begin
         level = q.half ? !mark_first : mark_first; // RULE11
         if (level)
         begin
            dur = bit_val ? one_mark_i : zero_mark_i; // RULE11
         end
         else
         begin
            dur = bit_val ? one_space_i : zero_space_i; // RULE11
         end
      end
      else
      begin
         level = q.word[IRG_SYM_LVL_BIT]; // RULE3
         dur = {2'b00, q.word[IRG_DUR_MSB:0]}; // RULE3
      end
   end

   // ==========================================================
   // Sequencer next state
   always_comb
   begin
      d = q;
      d.done = 1'b0;
      sym_done = 1'b0;
      // Repeat queue loading, ignored once full
      if (rpt_clear_i)
      begin
         d.rpt_cnt = 4'h0;
      end
      else if (rpt_wr_i && q.rpt_cnt != IRG_RPT_FULL)
      begin
         d.rpt_mem[q.rpt_cnt[2:0]] = rpt_data_i; // RULE5
         d.rpt_cnt = q.rpt_cnt + 4'h1;
      end
      // Repeat interval runs from the start of each frame
      if (q.busy && tick && q.tmr != {IRG_TMR_W{1'b1}})
      begin
         d.tmr = q.tmr + 24'h000001; // RULE6
      end
      case (q.st)
         IRG_ST_IDLE:
         begin
            d.gate = 1'b0;
            if (transmit_trigger_i) // RULE13
            begin
               d.st = IRG_ST_FETCH;
               d.src_rpt = 1'b0;
               d.tmr = IRG_TMR_RST;
               d.busy = 1'b1;
            end
         end
         IRG_ST_FETCH:
         begin
            if (tick)
            begin
               d.gate = 1'b0;
               d.half = 1'b0;
            end
            if (!tick)
            begin
               d.st = IRG_ST_FETCH; // Word boundaries fall on carrier ticks
            end
            else if (!q.src_rpt && code_valid)
            begin
               d.word = code_word; // RULE4
               d.bit_idx = irg_top_bit(code_word);
               d.st = IRG_ST_LOAD;
            end
            else if (q.src_rpt && {1'b0, q.rpt_idx} < q.rpt_cnt
                     && !(q.rpt_idx == 3'h0 && q.rpt_cnt == 4'h0))
            begin
               d.word = q.rpt_mem[q.rpt_idx]; // RULE5
               d.bit_idx = irg_top_bit(q.rpt_mem[q.rpt_idx]);
               d.rpt_idx = q.rpt_idx + 3'h1;
               d.st = IRG_ST_LOAD;
               if (q.rpt_idx == 3'h7)
               begin
                  d.src_rpt = 1'b0; // Last slot: frame ends next fetch
                  d.st = IRG_ST_LOAD;
               end
            end
            else if (key_held_i && q.rpt_cnt != 4'h0)
            begin
               d.st = IRG_ST_GAP; // RULE6
            end
            else
            begin
               d.st = IRG_ST_IDLE; // RULE19
               d.busy = 1'b0;
               d.done = 1'b1; // RULE16
            end
         end
         IRG_ST_LOAD:
         begin
            // Gate changes only on a tick, so a symbol spans whole ticks
            if (tick)
            begin
               if (dur == IRG_CNT_RST)
               begin
                  sym_done = 1'b1; // Empty symbols are skipped
               end
               else
               begin
                  d.cnt = dur;
                  d.gate = level; // RULE9
                  d.st = IRG_ST_SYM;
                  sym_done = (dur == IRG_CNT_ONE); // One tick, no count
               end
            end
         end
         IRG_ST_SYM:
         begin
            // Ends one tick early: the next boundary takes the last tick
            if (tick)
            begin
               d.cnt = q.cnt - IRG_CNT_ONE;
               sym_done = (d.cnt == IRG_CNT_ONE); // RULE3
            end
         end
         IRG_ST_GAP:
         begin
            d.gate = 1'b0;
            if (!key_held_i)
            begin
               d.st = IRG_ST_IDLE; // RULE19
               d.busy = 1'b0;
               d.done = 1'b1; // RULE16
            end
            else if (q.tmr >= repeat_interval_i)
            begin
               d.st = IRG_ST_FETCH; // RULE6
               d.src_rpt = 1'b1;
               d.rpt_idx = 3'h0;
               d.tmr = IRG_TMR_RST;
            end
         end
         default:
         begin
            d.st = IRG_ST_IDLE;
            d.gate = 1'b0;
            d.busy = 1'b0;
         end
      endcase
      // Advance to the next half, bit or word
      if (sym_done)
      begin
         d.st = IRG_ST_LOAD;
         if (!irg_is_logic(q.word))
         begin
            d.st = IRG_ST_FETCH; // RULE18
         end
         else if (!q.half)
         begin
            d.half = 1'b1;
         end
         else if (q.bit_idx == 4'h0)
         begin
            d.half = 1'b0;
            d.st = IRG_ST_FETCH; // RULE18
         end
         else
         begin
            d.half = 1'b0;
            d.bit_idx = q.bit_idx - 4'h1; // RULE18
         end
      end
      // Gated carrier through the optional inverter
      d.out = (q.gate && carrier) ^ invert_i; // RULE10
   end

   // State register
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.st <= IRG_ST_IDLE;
      end
      else
      begin
         q <= d;
      end
   end

endmodule : irg_top

// ### irg_top_chk.sv
// Port-level assertions for the infrared code transmitter
`timescale 1ns/1ps
module irg_top_chk
   import irg_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Watched ports
   input wire logic invert_i,
   input wire logic transmit_trigger_i,
   input wire logic rpt_wr_i,
   input wire logic rpt_clear_i,
   input wire logic [3:0] rpt_count_o,
   input wire logic busy_o,
   input wire logic tx_done_o,
   input wire logic ir_out_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // Sequences
   sequence idle_run;
      !busy_o [*3] ##0 $stable(invert_i);
   endsequence
   sequence rpt_add;
      rpt_wr_i && !rpt_clear_i && rpt_count_o < IRG_RPT_FULL;
   endsequence
   // ==========================================================
   // Assertions
   busy_start_a: assert property (
      !busy_o && transmit_trigger_i |=> busy_o)
      else $error("busy did not follow trigger");
   done_pulse_a: assert property (
      tx_done_o |=> !tx_done_o)
      else $error("done longer than one cycle");
   busy_end_a: assert property (
      $fell(busy_o) |-> tx_done_o || $past(tx_done_o))
      else $error("busy fell without done");
   idle_level_a: assert property (
      idle_run |-> ir_out_o == invert_i)
      else $error("idle line level wrong");
   rpt_incr_a: assert property (
      rpt_add |=> rpt_count_o == $past(rpt_count_o) + 4'h1)
      else $error("repeat store did not grow");
   rpt_clear_a: assert property (
      rpt_clear_i |=> rpt_count_o == 4'h0)
      else $error("repeat store not emptied");
   rpt_full_a: assert property (
      rpt_wr_i && !rpt_clear_i && rpt_count_o == IRG_RPT_FULL
      |=> rpt_count_o == IRG_RPT_FULL)
      else $error("full repeat store changed");
   rpt_keep_a: assert property (
      !rpt_wr_i && !rpt_clear_i |=> $stable(rpt_count_o))
      else $error("repeat store consumed");
   rpt_bound_a: assert property (
      rpt_count_o <= IRG_RPT_FULL)
      else $error("repeat count out of range");
endmodule : irg_top_chk
bind irg_top irg_top_chk u_chk (.clk_sys_i, .rst_n_i, .invert_i,
   .transmit_trigger_i, .rpt_wr_i, .rpt_clear_i, .rpt_count_o, .busy_o,
   .tx_done_o, .ir_out_o);

// ### irg_top_test.sv
// Self-checking bench for the infrared code transmitter
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("unexpected at %0t: got %h want %h", $time, got, exp); \
      end \
   end
module irg_top_test;
   import irg_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic infrared_clock_gate_i = 1'b1;
   logic [7:0] carrier_div_i = 8'h00;
   logic [15:0] carrier_high_i = 16'h0001;
   logic [15:0] carrier_low_i = 16'h0000;
   logic [15:0] one_mark_i = 16'h0003;
   logic [15:0] one_space_i = 16'h0004;
   logic [15:0] zero_mark_i = 16'h0005;
   logic [15:0] zero_space_i = 16'h0002;
   logic one_bit_order_select_i = 1'b0;
   logic zero_bit_order_select_i = 1'b0;
   logic invert_i = 1'b0;
   logic transmit_trigger_i = 1'b0;
   logic key_held_i = 1'b0;
   logic [23:0] repeat_interval_i = 24'h00003C;
   logic code_valid_i = 1'b0;
   logic [15:0] code_data_i = 16'h0000;
   logic rpt_wr_i = 1'b0;
   logic rpt_clear_i = 1'b0;
   logic [15:0] rpt_data_i = 16'h4004;
   logic code_ready_o, busy_o, tx_done_o, ir_out_o;
   logic [3:0] rpt_count_o;
   int mismatches = 0;
   int total_checks = 0;
   int seed = 46;
   int rise;
   int exp_w[$];
   // Clock
   always #2.5 clk_sys_i = ~clk_sys_i;
   // Design and emitter
   irg_top dut (.clk_sys_i, .rst_n_i, .infrared_clock_gate_i,
      .carrier_div_i, .carrier_high_i, .carrier_low_i,
      .one_mark_i, .one_space_i, .zero_mark_i, .zero_space_i,
      .one_bit_order_select_i, .zero_bit_order_select_i, .invert_i,
      .transmit_trigger_i, .key_held_i, .repeat_interval_i,
      .code_valid_i, .code_data_i, .code_ready_o, .rpt_wr_i,
      .rpt_clear_i, .rpt_data_i, .rpt_count_o, .busy_o, .tx_done_o,
      .ir_out_o);
   irg_emitter emitter (.clk_sys_i, .rst_n_i, .ir_i(ir_out_o));
   // ==========================================================
   // Tasks
   task automatic conclude();
      if (mismatches == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude
   // Offer a word, valid stays up until the next call or send
   task automatic push(input logic [15:0] w);
      @(negedge clk_sys_i);
      code_valid_i = 1'b1;
      code_data_i = w;
   endtask : push
   // Trigger, note the first lit cycle, wait for done
   task automatic send();
      int n;
      @(negedge clk_sys_i);
      code_valid_i = 1'b0;
      emitter.widths.delete();
      transmit_trigger_i = 1'b1;
      @(negedge clk_sys_i);
      transmit_trigger_i = 1'b0;
      n = 0;
      rise = -1;
      while (tx_done_o !== 1'b1)
      begin
         @(negedge clk_sys_i);
         n++;
         if (rise < 0 && ir_out_o === 1'b1)
            rise = n;
         if (emitter.widths.size() >= 3)
            key_held_i = 1'b0;
         // Clock gate held off: frame stalls dark until it is opened
         if (n == 40 && !infrared_clock_gate_i)
         begin
            `CHK(busy_o, 1'b1)
            `CHK(ir_out_o, 1'b0)
            infrared_clock_gate_i = 1'b1;
         end
         if (n > 5000)
         begin
            mismatches++;
            conclude();
         end
      end
      repeat (3) @(negedge clk_sys_i);
   endtask : send
   task automatic cmp_widths();
      `CHK(emitter.widths.size(), exp_w.size())
      foreach (exp_w[i])
         `CHK(emitter.widths[i], exp_w[i])
   endtask : cmp_widths
   // Expected mark widths of a logic-bit word, top bit first
   function automatic void logic_widths(input logic [15:0] w);
      int top;
      top = (w[14:11] > 4'hA) ? 10 : int'(w[14:11]);
      for (int i = top; i >= 0; i--)
         exp_w.push_back(w[i] ? int'(one_mark_i) : int'(zero_mark_i));
   endfunction : logic_widths
   // ==========================================================
   // Main sequence
   initial
   begin
      logic [15:0] w;
      int d0;
      repeat (3) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      `CHK(code_ready_o, 1'b1)
      `CHK(ir_out_o, 1'b0)
      `CHK(rpt_count_o, 4'h0)
      // Random logic-bit words, first two with an oversized length
      for (int k = 0; k < 6; k++)
      begin
         one_mark_i = 16'h0002 + 16'($unsigned($random(seed)) % 3);
         exp_w.delete();
         repeat (2)
         begin
            w = 16'h8000 | 16'($random(seed) & 32'h7FFF);
            if (k == 0)
               w[14:11] = 4'hF;
            logic_widths(w);
            push(w);
         end
         send();
         cmp_widths();
      end
      // Painted marks, each followed by a painted space
      exp_w.delete();
      for (int k = 0; k < 5; k++)
      begin
         w = 16'h4001 + 16'($unsigned($random(seed)) % 20);
         exp_w.push_back(int'(w[13:0]));
         push(w);
         push(16'h0003);
      end
      send();
      cmp_widths();
      // Carrier three high, two low inside a ten tick mark
      carrier_high_i = 16'h0003;
      carrier_low_i = 16'h0002;
      exp_w = {3, 3};
      push(16'h400A);
      send();
      cmp_widths();
      carrier_high_i = 16'h0001;
      carrier_low_i = 16'h0000;
      // Gate closed at trigger, then a tick every second cycle
      carrier_div_i = 8'h01;
      infrared_clock_gate_i = 1'b0;
      exp_w = {10 * (int'(carrier_div_i) + 1)};
      push(16'h400A);
      send();
      cmp_widths();
      carrier_div_i = 8'h00;
      // Space-first delays the first mark by the space length
      for (int b = 0; b < 2; b++)
      begin
         for (int s = 0; s < 2; s++)
         begin
            one_bit_order_select_i = s[0];
            zero_bit_order_select_i = s[0];
            push(16'h8000 | 16'(b));
            send();
            if (s == 0)
               d0 = rise;
         end
         `CHK(rise - d0, b ? int'(one_space_i) : int'(zero_space_i))
      end
      one_bit_order_select_i = 1'b0;
      zero_bit_order_select_i = 1'b0;
      // Idle line follows inversion
      invert_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      `CHK(ir_out_o, 1'b1)
      invert_i = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      // Fill the code queue past full, then drain it
      for (int k = 0; k < 34; k++)
      begin
         `CHK(code_ready_o, k < 33)
         push(16'h0001);
      end
      send();
      `CHK(code_ready_o, 1'b1)
      `CHK(busy_o, 1'b0)
      // Repeat store: overfill, clear over a write, keep one word
      rpt_wr_i = 1'b1;
      repeat (9) @(negedge clk_sys_i);
      `CHK(rpt_count_o, IRG_RPT_FULL)
      rpt_clear_i = 1'b1;
      @(negedge clk_sys_i);
      rpt_clear_i = 1'b0;
      @(negedge clk_sys_i);
      rpt_wr_i = 1'b0;
      `CHK(rpt_count_o, 4'h1)
      key_held_i = 1'b1;
      exp_w = {2, 4, 4};
      push(16'h4002);
      send();
      cmp_widths();
      `CHK(rpt_count_o, 4'h1)
      conclude();
   end
endmodule : irg_top_test
